//--- src/change_irq_route_pkg.sv
package change_irq_route_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_FLAGS   = 8'h00;
	localparam logic [7:0] OFF_CONFIG  = 8'h04;
	localparam logic [7:0] OFF_CONTROL = 8'h08;
	localparam logic [7:0] OFF_SOCKET  = 8'h0c;
	localparam logic [7:0] OFF_PINS    = 8'h10;

	// Flag and enable bit positions
	localparam int BIT_DETECT = 3;
	localparam int BIT_READY  = 2;
	localparam int BIT_WARN   = 1;
	localparam int BIT_DEAD   = 0;

	// Configuration field layout
	localparam int ROUTE_LSB = 4;
	localparam int ROUTE_W   = 4;
	localparam int EN_W      = 4;

	// Control register bit positions
	localparam int CTL_ACK_WRITE_ONE = 0;
	localparam int CTL_IO_SELECT     = 1;
	localparam int CTL_RING_EN       = 2;
	localparam int CTL_RESET_REMOVAL = 3;
	localparam int CTL_W             = 4;

	// Socket pin indexes
	localparam int PIN_DETECT1 = 0;
	localparam int PIN_DETECT2 = 1;
	localparam int PIN_READY   = 2;
	localparam int PIN_BVD2    = 3;
	localparam int PIN_BVD1    = 4;
	localparam int PIN_COUNT   = 5;

	// Reset values
	localparam logic [ROUTE_W-1:0] ROUTE_RESET = 4'h0;
	localparam logic [EN_W-1:0]    EN_RESET    = 4'h0;
	localparam logic [CTL_W-1:0]   CTL_RESET   = 4'h0;
	localparam logic [31:0]        RDATA_ZERO  = 32'h0000_0000;

	// Cycles before edges are trusted: two sync stages plus the edge register,
	// so reset values never read as a pin change
	localparam int ARM_CYCLES = 3;

	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_ACCESS = 2'h1
	} bus_state_t;

endpackage

//--- src/pin_event_if.sv
`timescale 1ns/10ps
interface pin_event_if #(
	parameter int WIDTH = 5
);
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] fall;

	modport producer (output level, output rise, output fall);
	modport consumer (input level, input rise, input fall);
endinterface

//--- src/pin_event_detect.sv
`timescale 1ns/10ps
module pin_event_detect #(
	parameter int              WIDTH     = 5,
	parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
)(
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] raw,
	pin_event_if.producer         ev
);
	import change_irq_route_pkg::*;

	logic [WIDTH-1:0]      meta;
	logic [WIDTH-1:0]      stable;
	logic [WIDTH-1:0]      prev;
	logic [ARM_CYCLES-1:0] arm;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta   <= IDLE_LEVEL;
			stable <= IDLE_LEVEL;
		end
		else
		begin
			meta   <= raw;
			stable <= meta;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prev <= IDLE_LEVEL;
		else
			prev <= stable;
	end

	// Hold off edges until the pipeline holds real pin levels
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			arm <= '0;
		else
			arm <= {arm[ARM_CYCLES-2:0], 1'b1};
	end

	assign ev.level = stable;
	assign ev.rise  = arm[ARM_CYCLES-1] ? (stable & ~prev) : '0;
	assign ev.fall  = arm[ARM_CYCLES-1] ? (~stable & prev) : '0;

endmodule // pin_event_detect

//--- src/card_status_change_irq.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// - Flag reads zero whenever its enable bit is zero.
// - Write-one mode: writing one to a flag clears it.
// - Interrupt output stays asserted while any flag is set.
// - Read-clear mode: reading the flag register clears every flag.
// - One shared level interrupt; no second interrupt for more events.
// - Flag register bits 7 to 4 read zero, read-only.
// - Bit 3 sets on any detect pin change when its enable set.
// - Socket detect bits clear on read or write-one; write-one also clears bit 3.
// - Bit 2 sets on ready rising edge if enabled; zero in I/O mode.
// - Bit 1 sets on battery warning if enabled; zero in I/O mode.
// - Bit 0: battery dead or status-change low; hidden with ring passthrough.
// - Route field bits 7-4; zero or reserved code drives the PCI line.
// - Route field resets to zero and clears on removal when enabled.
// - Config bits 3-0 enable detect, ready, warning, dead/status sources.
// - Without ring passthrough, status-change pin feeds bit 0 source.
// - Card-type bit: zero memory interface, one I/O interface.
module card_status_change_irq (
	input  wire logic                                  hclk,
	input  wire logic                                  hresetn,
	input  wire logic                                  hsel,
	input  wire logic [31:0]                           haddr,
	input  wire logic [1:0]                            htrans,
	input  wire logic                                  hwrite,
	input  wire logic [2:0]                            hsize,
	input  wire logic [31:0]                           hwdata,
	input  wire logic                                  hready,
	output logic      [31:0]                           hrdata,
	output logic                                       hreadyout,
	output logic                                       hresp,
	input  wire logic                                  card_detect1_n,
	input  wire logic                                  card_detect2_n,
	input  wire logic                                  ready_busy,
	input  wire logic                                  bvd2_warn_n,
	input  wire logic                                  bvd1_status_n,
	output logic                                       pci_inta_n,
	output logic      [15:0]                           isa_irq,
	output logic                                       ring_out_pin
);
	import change_irq_route_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic route_is_isa(input logic [ROUTE_W-1:0] code);
		case (code)
			4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf:
				route_is_isa = 1'b1;
			default:
				route_is_isa = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] isa_onehot(input logic [ROUTE_W-1:0] code);
		isa_onehot = 16'h0001 << code;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations

	pin_event_if #(.WIDTH(PIN_COUNT)) pins ();

	bus_state_t           state;
	logic [7:0]           acc_addr;
	logic                 acc_write;
	logic                 take;
	logic                 in_access;
	logic                 wr_flags;
	logic                 rd_flags;
	logic                 wr_config;
	logic                 wr_control;
	logic                 wr_socket;
	logic                 rd_socket;

	logic [ROUTE_W-1:0]   change_irq_route;
	logic [EN_W-1:0]      source_en;
	logic                 ack_write_one;
	logic                 io_interface_select;
	logic                 ring_passthrough_en;
	logic                 reset_on_removal_en;

	logic                 detect_change_flag;
	logic                 ready_rise_flag;
	logic                 batt_warn_flag;
	logic                 batt_dead_or_stat_flag;
	logic                 socket_detect1_event;
	logic                 socket_detect2_event;

	logic                 detect_change_en;
	logic                 ready_rise_en;
	logic                 batt_warn_en;
	logic                 batt_dead_en;
	logic                 io_ring_mode;
	logic                 detect1_change;
	logic                 detect2_change;
	logic                 card_removed;
	logic                 set_detect;
	logic                 set_ready;
	logic                 set_warn;
	logic                 set_dead;
	logic                 clr_detect;
	logic                 clr_ready;
	logic                 clr_warn;
	logic                 clr_dead;
	logic                 clr_sock1;
	logic                 clr_sock2;
	logic [7:0]           flags_view;
	logic                 irq_pending;
	logic [31:0]          read_value;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection

	pin_event_detect #(
		.WIDTH      (PIN_COUNT),
		.IDLE_LEVEL (5'h1f)
	) u_pins (
		.hclk    (hclk),
		.hresetn (hresetn),
		.raw     ({bvd1_status_n, bvd2_warn_n, ready_busy, card_detect2_n, card_detect1_n}),
		.ev      (pins.producer)
	);

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: one wait state per transfer, so write data and
	// read side effects settle before the next address can be acted on

	assign take      = hsel & hready & (htrans == HTRANS_NONSEQ);
	assign in_access = (state == ST_ACCESS);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state     <= ST_IDLE;
			acc_addr  <= 8'h00;
			acc_write <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (take)
					begin
						state     <= ST_ACCESS;
						acc_addr  <= haddr[7:0];
						acc_write <= hwrite;
					end
				end
				ST_ACCESS:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hreadyout <= 1'b1;
		else if (state == ST_IDLE && take)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= HRESP_OKAY;
		else
			hresp <= HRESP_OKAY;
	end

	assign wr_flags   = in_access & acc_write & (acc_addr == OFF_FLAGS);
	assign rd_flags   = in_access & ~acc_write & (acc_addr == OFF_FLAGS);
	assign wr_config  = in_access & acc_write & (acc_addr == OFF_CONFIG);
	assign wr_control = in_access & acc_write & (acc_addr == OFF_CONTROL);
	assign wr_socket  = in_access & acc_write & (acc_addr == OFF_SOCKET);
	assign rd_socket  = in_access & ~acc_write & (acc_addr == OFF_SOCKET);

	////////////////////////////////////////////////////////////////////////
	// Configuration and control registers

	assign detect_change_en = source_en[BIT_DETECT];
	assign ready_rise_en    = source_en[BIT_READY];
	assign batt_warn_en     = source_en[BIT_WARN];
	assign batt_dead_en     = source_en[BIT_DEAD];

	assign card_removed = (pins.rise[PIN_DETECT1] | pins.rise[PIN_DETECT2])
		& pins.level[PIN_DETECT1] & pins.level[PIN_DETECT2];

	// Removal wins over a simultaneous software write of the route
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			change_irq_route <= ROUTE_RESET;
		else if (reset_on_removal_en && card_removed)
			change_irq_route <= ROUTE_RESET;
		else if (wr_config)
			change_irq_route <= hwdata[ROUTE_LSB +: ROUTE_W];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			source_en <= EN_RESET;
		else if (wr_config)
			source_en <= hwdata[EN_W-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ack_write_one       <= CTL_RESET[CTL_ACK_WRITE_ONE];
			io_interface_select <= CTL_RESET[CTL_IO_SELECT];
			ring_passthrough_en <= CTL_RESET[CTL_RING_EN];
			reset_on_removal_en <= CTL_RESET[CTL_RESET_REMOVAL];
		end
		else if (wr_control)
		begin
			ack_write_one       <= hwdata[CTL_ACK_WRITE_ONE];
			io_interface_select <= hwdata[CTL_IO_SELECT];
			ring_passthrough_en <= hwdata[CTL_RING_EN];
			reset_on_removal_en <= hwdata[CTL_RESET_REMOVAL];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event sources

	assign io_ring_mode   = io_interface_select & ring_passthrough_en;
	assign detect1_change = pins.rise[PIN_DETECT1] | pins.fall[PIN_DETECT1];
	assign detect2_change = pins.rise[PIN_DETECT2] | pins.fall[PIN_DETECT2];

	assign set_detect = detect_change_en & (detect1_change | detect2_change);
	assign set_ready  = ready_rise_en & ~io_interface_select & pins.rise[PIN_READY];
	assign set_warn   = batt_warn_en & ~io_interface_select & pins.fall[PIN_BVD2];
	// Status-change pin is a source only when not passed to the ring pin
	assign set_dead   = batt_dead_en & ~io_ring_mode & pins.fall[PIN_BVD1];

	////////////////////////////////////////////////////////////////////////
	// Acknowledge decoding

	assign clr_sock1 = ack_write_one ? (wr_socket & hwdata[0]) : rd_socket;
	assign clr_sock2 = ack_write_one ? (wr_socket & hwdata[1]) : rd_socket;

	assign clr_detect = ack_write_one
		? ((wr_flags & hwdata[BIT_DETECT])
		| (clr_sock1 & socket_detect1_event)
		| (clr_sock2 & socket_detect2_event))
		: rd_flags;
	assign clr_ready = ack_write_one ? (wr_flags & hwdata[BIT_READY]) : rd_flags;
	assign clr_warn  = ack_write_one ? (wr_flags & hwdata[BIT_WARN]) : rd_flags;
	assign clr_dead  = ack_write_one ? (wr_flags & hwdata[BIT_DEAD]) : rd_flags;

	////////////////////////////////////////////////////////////////////////
	// Sticky flags; a set in the clearing cycle is kept

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			detect_change_flag <= 1'b0;
		else if (set_detect)
			detect_change_flag <= 1'b1;
		else if (clr_detect)
			detect_change_flag <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ready_rise_flag <= 1'b0;
		else if (set_ready)
			ready_rise_flag <= 1'b1;
		else if (clr_ready)
			ready_rise_flag <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			batt_warn_flag <= 1'b0;
		else if (set_warn)
			batt_warn_flag <= 1'b1;
		else if (clr_warn)
			batt_warn_flag <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			batt_dead_or_stat_flag <= 1'b0;
		else if (set_dead)
			batt_dead_or_stat_flag <= 1'b1;
		else if (clr_dead)
			batt_dead_or_stat_flag <= 1'b0;
	end

	// Socket-level detect change bits record every change, enabled or not
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			socket_detect1_event <= 1'b0;
			socket_detect2_event <= 1'b0;
		end
		else
		begin
			if (detect1_change)
				socket_detect1_event <= 1'b1;
			else if (clr_sock1)
				socket_detect1_event <= 1'b0;
			if (detect2_change)
				socket_detect2_event <= 1'b1;
			else if (clr_sock2)
				socket_detect2_event <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Visible flags and interrupt

	// Masking on read also hides flags left over after an enable drops
	always_comb
	begin
		flags_view             = 8'h00;
		flags_view[BIT_DETECT] = detect_change_flag & detect_change_en;
		flags_view[BIT_READY]  = ready_rise_flag & ready_rise_en
			& ~io_interface_select;
		flags_view[BIT_WARN]   = batt_warn_flag & batt_warn_en
			& ~io_interface_select;
		flags_view[BIT_DEAD]   = batt_dead_or_stat_flag & batt_dead_en
			& ~io_ring_mode;
	end

	// One level for all sources: extra events never pulse it again
	assign irq_pending = |flags_view;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pci_inta_n <= 1'b1;
		else
			pci_inta_n <= ~(irq_pending & ~route_is_isa(change_irq_route));
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			isa_irq <= 16'h0000;
		else if (irq_pending && route_is_isa(change_irq_route))
			isa_irq <= isa_onehot(change_irq_route);
		else
			isa_irq <= 16'h0000;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ring_out_pin <= 1'b1;
		else if (io_ring_mode)
			ring_out_pin <= pins.level[PIN_BVD1];
		else
			ring_out_pin <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data; the host must read the flags before leaving its handler

	always_comb
	begin
		read_value = RDATA_ZERO;
		case (acc_addr)
			OFF_FLAGS:
				read_value[7:0] = flags_view;
			OFF_CONFIG:
				read_value[7:0] = {change_irq_route, source_en};
			OFF_CONTROL:
				read_value[CTL_W-1:0] = {reset_on_removal_en, ring_passthrough_en,
					io_interface_select, ack_write_one};
			OFF_SOCKET:
				read_value[1:0] = {socket_detect2_event, socket_detect1_event};
			OFF_PINS:
				read_value[PIN_COUNT-1:0] = pins.level;
			default:
				read_value = RDATA_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= RDATA_ZERO;
		else if (in_access && !acc_write)
			hrdata <= read_value;
	end

endmodule // card_status_change_irq

//--- verification/card_status_change_irq_sva.sv
`timescale 1ns/10ps
module card_status_change_irq_sva
	import change_irq_route_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        card_detect1_n,
	input wire logic        card_detect2_n,
	input wire logic        ready_busy,
	input wire logic        bvd2_warn_n,
	input wire logic        bvd1_status_n,
	input wire logic        pci_inta_n,
	input wire logic [15:0] isa_irq,
	input wire logic        ring_out_pin
);
	logic       dp;
	logic       dwr;
	logic       chk;
	logic       rdf;
	logic       ring_on;
	logic [7:0] dad;
	logic [7:0] cad;
	logic [3:0] en;
	logic [3:0] rt;
	logic [3:0] ctl;
	logic [3:0] quiet;
	logic [4:0] lp;
	logic [4:0] pins;

	assign pins = {bvd1_status_n, bvd2_warn_n, ready_busy, card_detect2_n, card_detect1_n};
	assign rdf = chk && cad == OFF_FLAGS;
	assign ring_on = ctl[CTL_IO_SELECT] && ctl[CTL_RING_EN];

	function automatic logic rsv(input logic [3:0] c);
		return !(c inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf});
	endfunction

	////////////////////////////////////////////////////////////////
	// Bus phase tracking; chk marks the edge where read data is seen
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			{dp, dwr, dad, chk, cad} <= '0;
		else
		begin
			chk <= dp && !hreadyout && !dwr;
			cad <= dad;
			if (!dp)
				dp <= hsel && hready && htrans == HTRANS_NONSEQ;
			else if (!hreadyout)
				dp <= 1'b0;
			if (!dp)
			begin
				dwr <= hwrite;
				dad <= haddr[7:0];
			end
		end
	end

	// Shadow of what software wrote; removal clearing is not mirrored
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			{rt, en, ctl} <= '0;
		else if (dp && dwr && !hreadyout && dad == OFF_CONFIG)
			{rt, en} <= hwdata[7:0];
		else if (dp && dwr && !hreadyout && dad == OFF_CONTROL)
			ctl <= hwdata[3:0];
	end

	// Cycles since any socket pin moved, saturating
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			{lp, quiet} <= '0;
		else
		begin
			lp <= pins;
			if (pins != lp)
				quiet <= 4'h0;
			else if (quiet != 4'hf)
				quiet <= quiet + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_flag_hidden;
		rdf |-> (hrdata[3:0] & ~en) == 4'h0;
	endproperty
	a_flag_hidden: assert property (p_flag_hidden)
		else $error("flag visible while its enable is off");

	property p_irq_holds;
		!pci_inta_n && !dp && !$past(dp) |=> !pci_inta_n;
	endproperty
	a_irq_holds: assert property (p_irq_holds)
		else $error("interrupt dropped without a bus access");

	property p_read_clear;
		rdf && !ctl[CTL_ACK_WRITE_ONE] && quiet >= 4'h8 |-> ##[1:2] (pci_inta_n && isa_irq == 16'h0);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("flag read did not release interrupt");

	property p_one_line;
		!(!pci_inta_n && |isa_irq) && $onehot0(isa_irq);
	endproperty
	a_one_line: assert property (p_one_line)
		else $error("more than one interrupt line active");

	property p_upper_zero;
		rdf |-> hrdata[31:4] == 28'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("flag register upper bits not zero");

	property p_io_mask;
		rdf && ctl[CTL_IO_SELECT] |-> hrdata[2:1] == 2'h0;
	endproperty
	a_io_mask: assert property (p_io_mask)
		else $error("memory-only flag seen in io mode");

	property p_ring_mask;
		rdf && ring_on |-> !hrdata[0];
	endproperty
	a_ring_mask: assert property (p_ring_mask)
		else $error("status flag seen with ring passthrough");

	property p_reserved_route;
		rsv($past(rt)) |-> isa_irq == 16'h0;
	endproperty
	a_reserved_route: assert property (p_reserved_route)
		else $error("isa line driven for reserved route");

	property p_isa_code;
		|isa_irq |-> isa_irq == (16'h1 << $past(rt));
	endproperty
	a_isa_code: assert property (p_isa_code)
		else $error("isa line does not match route code");

	property p_ring_idle;
		!ring_on && !$past(ring_on) |-> ring_out_pin;
	endproperty
	a_ring_idle: assert property (p_ring_idle)
		else $error("ring output moved without passthrough");

	property p_resp_okay;
		hresp == HRESP_OKAY;
	endproperty
	a_resp_okay: assert property (p_resp_okay)
		else $error("slave response not okay");

	cover property (rdf && hrdata[3:0] != 4'h0);
	cover property (|isa_irq);
	cover property (!pci_inta_n && quiet == 4'hf);
endmodule // card_status_change_irq_sva

bind card_status_change_irq card_status_change_irq_sva i_card_status_change_irq_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .card_detect1_n(card_detect1_n),
	.card_detect2_n(card_detect2_n), .ready_busy(ready_busy), .bvd2_warn_n(bvd2_warn_n),
	.bvd1_status_n(bvd1_status_n), .pci_inta_n(pci_inta_n), .isa_irq(isa_irq),
	.ring_out_pin(ring_out_pin)
);

//--- verification/card_socket_model.sv
`timescale 1ns/10ps
module card_socket_model (
	input  wire logic hclk,
	output logic      card_detect1_n,
	output logic      card_detect2_n,
	output logic      ready_busy,
	output logic      bvd2_warn_n,
	output logic      bvd1_status_n
);
	// Seated card, busy, batteries good
	logic [4:0] pins = 5'h18;

	assign {bvd1_status_n, bvd2_warn_n, ready_busy, card_detect2_n, card_detect1_n} = pins;

	// Called right after a clock edge; the card moves its pins only then
	task automatic set_pins(input logic [4:0] v);
		pins <= v;
	endtask
endmodule // card_socket_model

//--- verification/tb_card_status_change_irq.sv
`timescale 1ns/10ps
module tb_card_status_change_irq;
	import change_irq_route_pkg::*;

	typedef struct packed {
		logic [3:0]  ctl;
		logic [7:0]  cfg;
		logic [4:0]  pins;
		logic [3:0]  flags;
		logic [17:0] lines;
	} row_t;

	localparam logic [4:0] BASE = 5'h18;
	// Lines are {ring_out_pin, pci_inta_n, isa_irq}
	localparam row_t ROWS [8] = '{
		'{4'h0, 8'h38, 5'h19, 4'h8, 18'h30008},
		'{4'h0, 8'h04, 5'h1c, 4'h4, 18'h20000},
		'{4'h0, 8'h52, 5'h10, 4'h2, 18'h30020},
		'{4'h0, 8'hf1, 5'h08, 4'h1, 18'h38000},
		'{4'h2, 8'h1f, 5'h04, 4'h1, 18'h20000},
		'{4'h6, 8'h61, 5'h08, 4'h0, 18'h10000},
		'{4'h0, 8'h70, 5'h07, 4'h0, 18'h30000},
		'{4'h0, 8'h9c, 5'h1e, 4'hc, 18'h30200}
	};

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hreadyout;
	logic        hresp;
	logic        det1_n;
	logic        det2_n;
	logic        rdy;
	logic        warn_n;
	logic        stat_n;
	logic        pci_inta_n;
	logic        ring_out_pin;
	logic [15:0] isa_irq;
	int          mismatches;
	int          comparisons;
	int          cycles;

	card_status_change_irq i_card_status_change_irq (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .card_detect1_n(det1_n),
		.card_detect2_n(det2_n), .ready_busy(rdy), .bvd2_warn_n(warn_n),
		.bvd1_status_n(stat_n), .pci_inta_n(pci_inta_n), .isa_irq(isa_irq),
		.ring_out_pin(ring_out_pin)
	);

	card_socket_model i_card_socket_model (
		.hclk(hclk), .card_detect1_n(det1_n), .card_detect2_n(det2_n),
		.ready_busy(rdy), .bvd2_warn_n(warn_n), .bvd1_status_n(stat_n)
	);

	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_lines(input logic [17:0] exp);
		chk_reg({14'h0, ring_out_pin, pci_inta_n, isa_irq}, {14'h0, exp});
	endtask

	// Entered just after a rising edge; one single word transfer
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= we;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk_reg(rd, exp);
	endtask

	function automatic logic [17:0] route_exp(input logic [3:0] c);
		logic ok;
		ok = c inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
		return {1'b1, ok, ok ? (16'h1 << c) : 16'h0};
	endfunction

	////////////////////////////////////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			test_done();
		end
	end

	initial
	begin
		row_t r;
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(OFF_CONFIG, 32'h0);
		rd_chk(OFF_CONTROL, 32'h0);
		wr(8'h40, 32'hff);
		rd_chk(8'h40, 32'h0);
		rd_chk(OFF_SOCKET, 32'h0);
		chk_lines(18'h30000);
		$display("done: reset values");
		foreach (ROWS[i])
		begin
			r = ROWS[i];
			wr(OFF_CONTROL, {28'h0, r.ctl});
			wr(OFF_CONFIG, {24'h0, r.cfg});
			i_card_socket_model.set_pins(r.pins);
			repeat (8) @(posedge hclk);
			chk_lines(r.lines);
			rd_chk(OFF_FLAGS, {28'h0, r.flags});
			rd_chk(OFF_FLAGS, 32'h0);
			repeat (2) @(posedge hclk);
			chk_lines({r.lines[17], 17'h10000});
			wr(OFF_CONFIG, 32'h0);
			i_card_socket_model.set_pins(BASE);
			repeat (8) @(posedge hclk);
		end
		$display("done: row table");
		wr(OFF_CONTROL, 32'h1);
		wr(OFF_CONFIG, 32'h08);
		i_card_socket_model.set_pins(5'h19);
		repeat (8) @(posedge hclk);
		for (int c = 0; c < 16; c++)
		begin
			wr(OFF_CONFIG, {24'h0, c[3:0], 4'h8});
			repeat (2) @(posedge hclk);
			chk_lines(route_exp(c[3:0]));
		end
		$display("done: route codes");
		wr(OFF_CONTROL, 32'h9);
		wr(OFF_CONFIG, 32'hb8);
		repeat (2) @(posedge hclk);
		chk_lines(18'h30800);
		i_card_socket_model.set_pins(5'h1b);
		repeat (8) @(posedge hclk);
		rd_chk(OFF_CONFIG, 32'h08);
		chk_lines(18'h20000);
		rd_chk(OFF_SOCKET, 32'h3);
		$display("done: removal");
		wr(OFF_CONFIG, 32'h4c);
		i_card_socket_model.set_pins(5'h1f);
		repeat (8) @(posedge hclk);
		rd_chk(OFF_FLAGS, 32'hc);
		wr(OFF_FLAGS, 32'h4);
		rd_chk(OFF_FLAGS, 32'h8);
		chk_lines(18'h30010);
		wr(OFF_SOCKET, 32'h1);
		rd_chk(OFF_FLAGS, 32'h0);
		rd_chk(OFF_SOCKET, 32'h2);
		chk_lines(18'h30000);
		wr(OFF_FLAGS, 32'hf0);
		rd_chk(OFF_FLAGS, 32'h0);
		rd_chk(OFF_PINS, 32'h1f);
		$display("done: write-one clear");
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(OFF_CONFIG, 32'h0);
		chk_lines(18'h30000);
		i_card_socket_model.set_pins(5'h1d);
		repeat (8) @(posedge hclk);
		rd_chk(OFF_SOCKET, 32'h2);
		rd_chk(OFF_SOCKET, 32'h0);
		$display("done: reset in mid-run");
		test_done();
	end
endmodule // tb_card_status_change_irq
